// File: common/eled_pkg.sv
// constants for the enhanced indicator controller
package eled_pkg;
   // register addresses in the management space
   localparam logic [4:0]  ADDR_FUNC_SEL   = 5'h10;
   localparam logic [4:0]  ADDR_BEHAV_CTL  = 5'h11;
   localparam logic [4:0]  ADDR_PAGE       = 5'h1f;
   localparam logic [15:0] PAGE_EXTENDED   = 16'h0001;
   localparam logic [15:0] PAGE_NORMAL     = 16'h0000;
   // function select field positions and reset codes
   localparam int          FSEL_W          = 4;
   localparam int          FSEL2_LSB       = 8;
   localparam int          FSEL1_LSB       = 4;
   localparam int          FSEL0_LSB       = 0;
   localparam logic [3:0]  FSEL2_RST       = 4'h2;
   localparam logic [3:0]  FSEL1_RST       = 4'h1;
   localparam logic [3:0]  FSEL0_RST       = 4'ha;
   localparam logic [15:0] FSEL_MASK       = 16'h0fff;
   // behaviour control field positions and reset value
   localparam int          BEH_PULSE_BIT   = 12;
   localparam int          BEH_RATE_LSB    = 10;
   localparam int          BEH_STRETCH_LSB = 5;
   localparam int          BEH_METHOD_BIT  = 4;
   localparam int          BEH_NOCOMB_LSB  = 0;
   localparam logic [15:0] BEH_MASK        = 16'h1cf7;
   localparam logic [15:0] BEH_RST         = 16'h04a0;
   // function codes
   localparam logic [3:0]  FN_LINK_ANY     = 4'h0;
   localparam logic [3:0]  FN_LINK_1000    = 4'h1;
   localparam logic [3:0]  FN_LINK_100     = 4'h2;
   localparam logic [3:0]  FN_LINK_10      = 4'h3;
   localparam logic [3:0]  FN_LINK_100_1G  = 4'h4;
   localparam logic [3:0]  FN_LINK_10_1G   = 4'h5;
   localparam logic [3:0]  FN_LINK_10_100  = 4'h6;
   localparam logic [3:0]  FN_DUPLEX_COL   = 4'h8;
   localparam logic [3:0]  FN_COLLISION    = 4'h9;
   localparam logic [3:0]  FN_ACTIVITY     = 4'ha;
   localparam logic [3:0]  FN_ANEG_FAULT   = 4'hc;
   localparam logic [3:0]  FN_FORCE_OFF    = 4'he;
   localparam logic [3:0]  FN_FORCE_ON     = 4'hf;
   // speed encoding from the status logic
   localparam logic [1:0]  SPD_10          = 2'h0;
   localparam logic [1:0]  SPD_100         = 2'h1;
   localparam logic [1:0]  SPD_1000        = 2'h2;
   // timing
   localparam int          CLK_HZ          = 50_000_000;
   localparam int          TICK_HZ         = 40;      // half period of 20 Hz
   localparam int          TICK_CYC        = CLK_HZ / TICK_HZ;
   localparam int          PULSE_HZ        = 5_000;
   localparam int          PULSE_CYC       = CLK_HZ / PULSE_HZ;
   localparam int          PULSE_DUTY_PCT  = 20;
   localparam int          PULSE_ON_CYC    = PULSE_CYC * PULSE_DUTY_PCT / 100;
   // ticks of 25 ms per blink period / stretch time: rate 00..11
   localparam int          STR_MS_R0       = 400;
   localparam int          TICK_MS         = 25;
   localparam logic [4:0]  TICKS_R0        = 5'(STR_MS_R0 / TICK_MS);
endpackage

// File: hw/eled_output.sv
`timescale 1ns/100ps
// one indicator output: function decode, blink or stretch, pulsing
module eled_output
   import eled_pkg::*;
(
   input  wire logic        clock,
   input  wire logic        reset_n,
   input  wire logic [3:0]  func_code,
   input  wire logic        stretch_sel,
   input  wire logic        no_combine,
   input  wire logic [4:0]  period_ticks,
   input  wire logic        tick,
   input  wire logic        blink_phase,
   input  wire logic        pulse_on,
   input  wire logic        pulse_enable,
   input  wire logic        link_up,
   input  wire logic [1:0]  link_speed,
   input  wire logic        full_duplex,
   input  wire logic        activity,
   input  wire logic        collision,
   input  wire logic        aneg_fault,
   output logic             lit
);
   logic [4:0] hold_reg;
   logic [4:0] hold_next;
   logic       lit_next;
   logic       speed_ok;
   logic       base;
   logic       event_in;
   logic       uses_event;
   logic       event_live;
   logic       shown;

   // speed qualification for the link codes
   always_comb begin
      unique case (func_code)
         FN_LINK_ANY:    speed_ok = 1'b1;
         FN_LINK_1000:   speed_ok = (link_speed == SPD_1000);
         FN_LINK_100:    speed_ok = (link_speed == SPD_100);
         FN_LINK_10:     speed_ok = (link_speed == SPD_10);
         FN_LINK_100_1G: speed_ok = (link_speed != SPD_10);
         FN_LINK_10_1G:  speed_ok = (link_speed != SPD_100);
         FN_LINK_10_100: speed_ok = (link_speed != SPD_1000);
         default:        speed_ok = 1'b0;
      endcase
   end

   // base level, event and whether the code shows events at all
   always_comb begin
      base       = 1'b0;
      event_in   = 1'b0;
      uses_event = 1'b0;
      if (func_code <= FN_LINK_10_100) begin
         base       = link_up & speed_ok;
         uses_event = base & ~no_combine;
         event_in   = uses_event & activity;
      end else begin
         unique case (func_code)
            FN_DUPLEX_COL: begin
               base       = link_up & full_duplex;
               uses_event = ~no_combine;
               event_in   = uses_event & collision;
            end
            FN_COLLISION: begin
               uses_event = 1'b1;
               event_in   = collision;
            end
            FN_ACTIVITY: begin
               uses_event = 1'b1;
               event_in   = activity;
            end
            FN_ANEG_FAULT: base = aneg_fault;
            FN_FORCE_ON:   base = 1'b1;
            default:       base = 1'b0;               // off and reserved
         endcase
      end
   end

   // stretch holds the event for the rate time; blink toggles while active
   always_comb begin
      hold_next = hold_reg;
      // a code that shows no events drops a stretch left by the old code; a new event code keeps it
      if (!uses_event)
         hold_next = 5'h00;
      else if (event_in)
         hold_next = period_ticks;
      else if (tick && hold_reg != 5'h00)
         hold_next = hold_reg - 5'h01;
      event_live = uses_event & (event_in | (hold_reg != 5'h00));
      if (stretch_sel)
         shown = base ^ event_live;
      else
         shown = base ^ (event_live & blink_phase);
      // pulsed drive only reduces duty, never lights a dark output
      lit_next = shown & (~pulse_enable | pulse_on);
   end

   // register the hold counter and the output
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         hold_reg <= 5'h00;
         lit      <= 1'b0;
      end else begin
         hold_reg <= hold_next;
         lit      <= lit_next;
      end
   end
endmodule // eled_output

// File: hw/eled_ctrl.sv
`timescale 1ns/100ps
// enhanced indicator controller with its two extended-page registers
module eled_ctrl
   import eled_pkg::*;
(
   input  wire logic        clock,
   input  wire logic        reset_n,
   input  wire logic        soft_reset,
   input  wire logic        sticky_enable,
   input  wire logic        page_extended,
   input  wire logic [4:0]  mgmt_addr,
   input  wire logic        mgmt_write,
   input  wire logic [15:0] mgmt_wdata,
   output logic      [15:0] mgmt_rdata,
   output logic             mgmt_hit,
   input  wire logic [2:0]  simple_drive,
   input  wire logic        link_up,
   input  wire logic [1:0]  link_speed,
   input  wire logic        full_duplex,
   input  wire logic        activity,
   input  wire logic        collision,
   input  wire logic        aneg_fault,
   output logic             indicator_out_zero,
   output logic             indicator_out_one,
   output logic             indicator_out_two
);
   localparam logic [15:0] FSEL_RST =
      {4'h0, FSEL2_RST, FSEL1_RST, FSEL0_RST};

   logic [15:0] fsel_reg;
   logic [15:0] fsel_next;
   logic [15:0] beh_reg;
   logic [15:0] beh_next;
   logic [20:0] tick_cnt_reg;
   logic [20:0] tick_cnt_next;
   logic [13:0] pulse_cnt_reg;
   logic [13:0] pulse_cnt_next;
   logic [4:0]  phase_cnt_reg;
   logic [4:0]  phase_cnt_next;
   logic        blink_reg;
   logic        blink_next;
   logic        tick;
   logic        pulse_on;
   logic [4:0]  period_ticks;
   logic [2:0]  enh_lit;
   logic [2:0]  sel_lit;
   logic        wr_fsel;
   logic        wr_beh;

   // decode of an extended-page access; page set by the outside party
   function automatic logic ext_hit(input logic [4:0] a, input logic pg,
                                    input logic [4:0] want);
      return pg && (a == want);
   endfunction

   assign wr_fsel  = mgmt_write & ext_hit(mgmt_addr, page_extended,
                                          ADDR_FUNC_SEL);
   assign wr_beh   = mgmt_write & ext_hit(mgmt_addr, page_extended,
                                          ADDR_BEHAV_CTL);
   assign mgmt_hit = ext_hit(mgmt_addr, page_extended, ADDR_FUNC_SEL) |
                     ext_hit(mgmt_addr, page_extended, ADDR_BEHAV_CTL);

   // read mux; reserved bits read zero
   always_comb begin
      if (ext_hit(mgmt_addr, page_extended, ADDR_FUNC_SEL))
         mgmt_rdata = fsel_reg;
      else if (ext_hit(mgmt_addr, page_extended, ADDR_BEHAV_CTL))
         mgmt_rdata = beh_reg;
      else
         mgmt_rdata = 16'h0000;
   end

   // register writes; soft reset restores defaults only without retention
   always_comb begin
      fsel_next = fsel_reg;
      beh_next  = beh_reg;
      if (soft_reset && !sticky_enable) begin
         fsel_next = FSEL_RST;
         beh_next  = BEH_RST;
      end else if (!soft_reset) begin                  // kept otherwise
         if (wr_fsel)
            fsel_next = mgmt_wdata & FSEL_MASK;
         if (wr_beh)
            beh_next = mgmt_wdata & BEH_MASK;
      end
   end

   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         fsel_reg <= FSEL_RST;
         beh_reg  <= BEH_RST;
      end else begin
         fsel_reg <= fsel_next;
         beh_reg  <= beh_next;
      end
   end

   // 25 ms tick enable; every slower rate is counted in these ticks
   always_comb begin
      tick          = (tick_cnt_reg == 21'(TICK_CYC - 1));
      tick_cnt_next = tick ? 21'h00_0000 : tick_cnt_reg + 21'h00_0001;
   end

   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         tick_cnt_reg <= 21'h00_0000;
      end else begin
         tick_cnt_reg <= tick_cnt_next;
      end
   end

   // blink phase; half blink period is half the stretch time, so one
   // rate field serves both behaviours
   always_comb begin
      // rate 00 = 16 ticks of 25 ms; each step halves it
      period_ticks   = TICKS_R0 >> beh_reg[BEH_RATE_LSB +: 2];
      phase_cnt_next = phase_cnt_reg;
      blink_next     = blink_reg;
      if (tick) begin
         if (phase_cnt_reg + 5'h01 >= (period_ticks >> 1)) begin
            phase_cnt_next = 5'h00;
            blink_next     = ~blink_reg;
         end else begin
            phase_cnt_next = phase_cnt_reg + 5'h01;
         end
      end
   end

   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         phase_cnt_reg <= 5'h00;
         blink_reg     <= 1'b0;
      end else begin
         phase_cnt_reg <= phase_cnt_next;
         blink_reg     <= blink_next;
      end
   end

   // 5 kHz pulse waveform, shared so that all outputs pulse in step
   always_comb begin
      pulse_cnt_next = (pulse_cnt_reg == 14'(PULSE_CYC - 1)) ? 14'h0000
                       : pulse_cnt_reg + 14'h0001;
      pulse_on       = (pulse_cnt_reg < 14'(PULSE_ON_CYC));
   end

   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         pulse_cnt_reg <= 14'h0000;
      end else begin
         pulse_cnt_reg <= pulse_cnt_next;
      end
   end

   // one output slice per indicator
   for (genvar i = 0; i < 3; i++) begin : g_out
      eled_output u_out (
         .clock        (clock),
         .reset_n      (reset_n),
         .func_code    (fsel_reg[i*FSEL_W +: FSEL_W]),
         .stretch_sel  (beh_reg[BEH_STRETCH_LSB + i]),
         .no_combine   (beh_reg[BEH_NOCOMB_LSB + i]),
         .period_ticks (period_ticks),
         .tick         (tick),
         .blink_phase  (blink_reg),
         .pulse_on     (pulse_on),
         .pulse_enable (beh_reg[BEH_PULSE_BIT]),
         .link_up      (link_up),
         .link_speed   (link_speed),
         .full_duplex  (full_duplex),
         .activity     (activity),
         .collision    (collision),
         .aneg_fault   (aneg_fault),
         .lit          (enh_lit[i])
      );
   end

   // method select: the unused scheme has no influence
   assign sel_lit = beh_reg[BEH_METHOD_BIT] ? enh_lit : simple_drive;
   assign indicator_out_zero = sel_lit[0];
   assign indicator_out_one  = sel_lit[1];
   assign indicator_out_two  = sel_lit[2];
endmodule // eled_ctrl

// File: tb/eled_checker.sv
// port-level assertions for the enhanced indicator controller
`timescale 1ns/100ps
module eled_checker
   import eled_pkg::*;
(
   input wire logic        clock,
   input wire logic        reset_n,
   input wire logic        soft_reset,
   input wire logic        sticky_enable,
   input wire logic        page_extended,
   input wire logic [4:0]  mgmt_addr,
   input wire logic        mgmt_write,
   input wire logic [15:0] mgmt_wdata,
   input wire logic [15:0] mgmt_rdata,
   input wire logic        mgmt_hit,
   input wire logic [2:0]  simple_drive,
   input wire logic        indicator_out_zero,
   input wire logic        indicator_out_one,
   input wire logic        indicator_out_two
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (!reset_n);
   // decoded reads of the two extended-page registers
   wire logic fs_rd = mgmt_hit && mgmt_addr == ADDR_FUNC_SEL;
   wire logic bh_rd = mgmt_hit && mgmt_addr == ADDR_BEHAV_CTL;
   wire logic [2:0] lamp = {indicator_out_two, indicator_out_one,
                            indicator_out_zero};
   property p_hit;
      mgmt_hit == (page_extended && (mgmt_addr == ADDR_FUNC_SEL
                   || mgmt_addr == ADDR_BEHAV_CTL));
   endproperty
   a_hit: assert property (p_hit) else $error("bad hit decode");
   property p_idle_rd;
      !mgmt_hit |-> mgmt_rdata == 16'h0000;
   endproperty
   a_idle_rd: assert property (p_idle_rd) else $error("rdata not 0");
   property p_fs_mask;
      fs_rd |-> (mgmt_rdata & ~FSEL_MASK) == 16'h0000;
   endproperty
   a_fs_mask: assert property (p_fs_mask) else $error("fsel rsvd");
   property p_bh_mask;
      bh_rd |-> (mgmt_rdata & ~BEH_MASK) == 16'h0000;
   endproperty
   a_bh_mask: assert property (p_bh_mask) else $error("behav rsvd");
   property p_fs_wr;
      (mgmt_write && fs_rd && !soft_reset) ##1 fs_rd
         |-> mgmt_rdata == ($past(mgmt_wdata) & FSEL_MASK);
   endproperty
   a_fs_wr: assert property (p_fs_wr) else $error("fsel write");
   property p_bh_wr;
      (mgmt_write && bh_rd && !soft_reset) ##1 bh_rd
         |-> mgmt_rdata == ($past(mgmt_wdata) & BEH_MASK);
   endproperty
   a_bh_wr: assert property (p_bh_wr) else $error("behav write");
   // simple method passes the simple levels straight through
   property p_simple;
      bh_rd && !mgmt_rdata[BEH_METHOD_BIT] |-> lamp == simple_drive;
   endproperty
   a_simple: assert property (p_simple) else $error("simple drive");
   property p_soft_dflt;
      (soft_reset && !sticky_enable) ##1 bh_rd |-> mgmt_rdata == BEH_RST;
   endproperty
   a_soft_dflt: assert property (p_soft_dflt) else $error("dflt");
   property p_sticky;
      (soft_reset && sticky_enable && bh_rd) ##1 bh_rd |-> $stable(mgmt_rdata);
   endproperty
   a_sticky: assert property (p_sticky) else $error("sticky lost");
   c_wr: cover property (mgmt_write && fs_rd);
   c_soft: cover property (soft_reset && !sticky_enable);
   c_on: cover property (lamp == 3'b111);
endmodule // eled_checker

bind eled_ctrl eled_checker u_chk (.clock(clock), .reset_n(reset_n),
   .soft_reset(soft_reset), .sticky_enable(sticky_enable),
   .page_extended(page_extended), .mgmt_addr(mgmt_addr),
   .mgmt_write(mgmt_write), .mgmt_wdata(mgmt_wdata),
   .mgmt_rdata(mgmt_rdata), .mgmt_hit(mgmt_hit),
   .simple_drive(simple_drive), .indicator_out_zero(indicator_out_zero),
   .indicator_out_one(indicator_out_one),
   .indicator_out_two(indicator_out_two));

// File: tb/eled_led_model.sv
// three indicator lamps that tally the cycles they are lit
`timescale 1ns/100ps
module eled_led_model (
   input  wire logic        clock,
   input  wire logic        clear,
   input  wire logic [2:0]  lamp,
   output logic      [15:0] on_count [3]
);
   // lit time is what the eye integrates, so only the tally matters
   always_ff @(posedge clock) begin
      for (int i = 0; i < 3; i++) begin
         on_count[i] <= clear ? 16'h0000 : on_count[i] + 16'(lamp[i]);
      end
   end
endmodule // eled_led_model

// File: tb/enhanced_led_controller_tb.sv
// self-checking bench for the enhanced indicator controller
`timescale 1ns/100ps
`define CHK(nm, ex, got) \
   n_tests++; \
   if ((got) !== (ex)) begin \
      err_count++; \
      $display("unexpected %s exp %h got %h", nm, ex, got); \
   end
module enhanced_led_controller_tb;
   import eled_pkg::*;
   typedef struct packed {
      logic wr; logic pg; logic [4:0] a; logic [15:0] d; logic [15:0] q;
   } eled_row_s;
   logic        clock, reset_n, soft_reset, sticky_enable, page_extended;
   logic [4:0]  mgmt_addr;
   logic        mgmt_write, link_up, full_duplex, activity, collision;
   logic [15:0] mgmt_wdata, mgmt_rdata;
   logic        mgmt_hit, aneg_fault, clear;
   logic [2:0]  simple_drive;
   wire logic [2:0] lamp;
   logic [1:0]  link_speed;
   logic [15:0] on_count [3];
   int          err_count = 0;
   int          n_tests = 0;
   // lit codes per speed 10, 100, 1000: link up, full duplex, fault set
   logic [15:0] code_map [3] = '{16'h9169, 16'h9155, 16'h9133};
   // write or not, page, address, data, expected read back
   eled_row_s rows [5] = '{'{1, 1, 5'h10, 16'hffff, 16'h0fff},
      '{1, 1, 5'h11, 16'hffff, 16'h1cf7}, '{1, 1, 5'h12, 16'h1234, 16'h0},
      '{1, 0, 5'h10, 16'h0000, 16'h0}, '{0, 1, 5'h10, 16'h0, 16'h0fff}};
   eled_ctrl uut (.clock(clock), .reset_n(reset_n), .soft_reset(soft_reset),
      .sticky_enable(sticky_enable), .page_extended(page_extended),
      .mgmt_addr(mgmt_addr), .mgmt_write(mgmt_write),
      .mgmt_wdata(mgmt_wdata), .mgmt_rdata(mgmt_rdata), .mgmt_hit(mgmt_hit),
      .simple_drive(simple_drive), .link_up(link_up),
      .link_speed(link_speed), .full_duplex(full_duplex),
      .activity(activity), .collision(collision), .aneg_fault(aneg_fault),
      .indicator_out_zero(lamp[0]), .indicator_out_one(lamp[1]),
      .indicator_out_two(lamp[2]));
   eled_led_model leds (.clock(clock), .clear(clear), .lamp(lamp),
      .on_count(on_count));
   task automatic end_of_test;
      $display("checks %0d mismatches %0d", n_tests, err_count);
      if (err_count == 0 && n_tests > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   // extended page selected in the same cycle as every write; reads keep the page as left
   task automatic wr(input logic [4:0] a, input logic [15:0] d);
      @(posedge clock);
      page_extended <= 1'b1;
      {mgmt_addr, mgmt_wdata, mgmt_write} <= {a, d, 1'b1};
      @(posedge clock);
      mgmt_write <= 1'b0;
   endtask
   task automatic rd(input logic [4:0] a, input logic [15:0] ex);
      @(posedge clock);
      mgmt_addr <= a;
      @(negedge clock);
      `CHK("rdata", ex, mgmt_rdata)
   endtask
   initial begin
      clock = 1'b0;
      forever #10 clock = ~clock;
   end
   // a hang ends the run through the same report
   initial begin
      repeat (60000) @(posedge clock);
      err_count++;
      end_of_test();
   end
   initial begin
      {reset_n, soft_reset, sticky_enable, page_extended} = 4'b0011;
      {mgmt_addr, mgmt_write, mgmt_wdata, clear} = '0;
      {simple_drive, link_up, link_speed, full_duplex} = {3'b101, 1'b1,
         SPD_1000, 1'b1};
      {activity, collision, aneg_fault} = 3'b001;
      repeat (10) @(posedge clock);
      reset_n <= 1'b1;
      rd(ADDR_FUNC_SEL, 16'h021a);
      rd(ADDR_BEHAV_CTL, 16'h04a0);
      `CHK("simple", 3'b101, lamp)
      $display("reset test done");
      foreach (rows[i]) begin
         @(posedge clock);
         {mgmt_write, page_extended, mgmt_addr, mgmt_wdata} <= rows[i][38:16];
         @(posedge clock);
         mgmt_write <= 1'b0;
         @(negedge clock);
         `CHK("row rdata", rows[i].q, mgmt_rdata)
      end
      $display("register rows done");
      // bit c of the map: code c lit at that speed with link up, full duplex, fault
      wr(ADDR_BEHAV_CTL, 16'h0010);
      for (int s = 0; s < 3; s++) begin
         @(posedge clock);
         link_speed <= 2'(s);
         for (int c = 0; c < 16; c++) begin
            wr(ADDR_FUNC_SEL, {4'h0, {3{c[3:0]}}});
            repeat (2) @(negedge clock);
            `CHK("code", {3{1'(code_map[s] >> c)}}, lamp)
         end
      end
      $display("function codes done");
      // stretched activity inverts only the combined outputs
      wr(ADDR_FUNC_SEL, 16'h0000);
      wr(ADDR_BEHAV_CTL, 16'h00f1);
      activity <= 1'b1;
      @(posedge clock);
      activity <= 1'b0;
      repeat (3) @(negedge clock);
      `CHK("combine", 3'b001, lamp)
      wr(ADDR_BEHAV_CTL, 16'h1010);
      wr(ADDR_FUNC_SEL, 16'h0fff);
      clear <= 1'b1;
      @(posedge clock);
      clear <= 1'b0;
      repeat (PULSE_CYC) @(posedge clock);
      @(negedge clock);
      foreach (on_count[i]) begin
         `CHK("on cycles", 16'(PULSE_ON_CYC), on_count[i])
      end
      wr(ADDR_BEHAV_CTL, 16'h1000);
      simple_drive <= 3'b010;
      @(negedge clock);
      `CHK("method off", 3'b010, lamp)
      $display("drive tests done");
      wr(ADDR_BEHAV_CTL, 16'h0c00);
      @(posedge clock);
      soft_reset <= 1'b1;
      @(posedge clock);
      soft_reset <= 1'b0;
      rd(ADDR_BEHAV_CTL, 16'h0c00);
      @(posedge clock);
      {sticky_enable, soft_reset, mgmt_wdata, mgmt_write} <= {2'b01,
         16'h1cf7, 1'b1};
      @(posedge clock);
      {soft_reset, mgmt_write} <= 2'b00;
      rd(ADDR_BEHAV_CTL, BEH_RST);
      rd(ADDR_FUNC_SEL, 16'h021a);
      $display("soft reset test done");
      end_of_test();
   end
endmodule // enhanced_led_controller_tb
